// ==== core/sffc_pkg.sv ====
// Constants, register map and field layout for the supply fault, mirror status and diagnostic mask logic
// Overview of operation
// RULE1 - On supply undervoltage all output stages are switched off at once and the supply-low flag is set.
// RULE2 - With the fault latch control bit low, outputs resume once undervoltage ends; with it high the host must first clear the supply-low flag.
// RULE3 - On supply overvoltage all output stages are switched off at once and the supply-high flag is set.
// RULE4 - With the fault latch control bit low, outputs resume once overvoltage ends; with it high the host must first clear the supply-high flag.
// RULE5 - The mirror status pair reads 00 in range, above-target alone when high, below-target alone when low, and 11 is never produced.
// RULE6 - In mirror mode a comparator deviation shows in the status pair only after it has lasted at least 32 us.
// RULE7 - The mirror status bits follow the comparators unlatched and change no sooner than 32 us apart.
// RULE8 - The mirror status bits never feed the global error flag.
// RULE9 - Config bits D5 and D4 keep underload on high-side 1 and low-side 1 out of the global underload flag.
// RULE10 - Config bit D1 keeps every output's underload out of the global underload flag.
// RULE11 - Config bit D3 suppresses the global thermal warning flag; at zero, the reset value, it works normally.
// RULE12 - The configuration register sits at 3Fh, has writable bits D7, D5, D4, D3 and D1, and resets to zero.
// RULE13 - With the mirror PWM discharge bit set, PWM discharge is applied on the mirror output and its overcurrent recovery is disabled.
// RULE14 - Any unmasked per-output underload event also sets the global underload flag.
// RULE15 - Reserved configuration bits read as zero and ignore writes.
package sffc_pkg;
    localparam int REG_ADDR_W = 6;
    localparam int REG_DATA_W = 16;
    localparam logic [REG_ADDR_W-1:0] CONFIG_ADDR = 6'h3F;
    localparam logic [REG_ADDR_W-1:0] STATUS2_ADDR = 6'h12;
    localparam logic [REG_DATA_W-1:0] CONFIG_RESET = 16'h0000;
    localparam logic [REG_DATA_W-1:0] CONFIG_WMASK = 16'h00BA;
    // Config field positions
    localparam int CFG_PWM_DIS = 7;
    localparam int CFG_MASK_ULD_HIGH1 = 5;
    localparam int CFG_MASK_ULD_LOW1 = 4;
    localparam int CFG_MASK_THERM = 3;
    localparam int CFG_MASK_ULD_ALL = 1;
    // Status field positions
    localparam int ST_UV = 3;
    localparam int ST_OV = 2;
    localparam int ST_BELOW = 1;
    localparam int ST_ABOVE = 0;
    // Underload vector positions
    localparam int ULD_HS1 = 0;
    localparam int ULD_LS1 = 1;
    // Mirror filter time
    localparam int CLK_MHZ = 40;
    localparam int EC_FILT_US = 32;
    localparam int EC_FILT_CYC = EC_FILT_US * CLK_MHZ;
    localparam int SYNC_STAGES = 3;
    typedef enum logic [1:0] {SFFC_IN_RANGE, SFFC_ABOVE, SFFC_BELOW} sffc_ec_e;
endpackage

// ==== core/sffc_ec_filter.sv ====
// Mirror comparator filter: synchronises both comparators and holds each status change for a minimum time
module sffc_ec_filter
    import sffc_pkg::*;
#(
    parameter int FILT_CYC = EC_FILT_CYC
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic clkEn,
    input wire logic ecMode,
    input wire logic cmpAbove,
    input wire logic cmpBelow,
    output logic ecAbove,
    output logic ecBelow
);
    localparam int CW = $clog2(FILT_CYC + 1);
    localparam logic [CW-1:0] CNT_MAX = CW'(FILT_CYC - 1);

    logic [SYNC_STAGES-1:0] aboveSync;
    logic [SYNC_STAGES-1:0] belowSync;
    logic aboveStable;
    logic belowStable;
    sffc_ec_e candidate;
    sffc_ec_e shown_reg;
    sffc_ec_e last_reg;
    logic [CW-1:0] cnt_reg;

    // Three-stage synchronisers; stage 0 feeds only stage 1
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            aboveSync <= '0;
            belowSync <= '0;
        end else if (clkEn) begin
            aboveSync <= {aboveSync[SYNC_STAGES-2:0], cmpAbove};
            belowSync <= {belowSync[SYNC_STAGES-2:0], cmpBelow};
        end
    end

    // Hold the last agreed level until stages two and three match
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            aboveStable <= 1'b0;
            belowStable <= 1'b0;
        end else if (clkEn) begin
            if (aboveSync[1] == aboveSync[2]) begin
                aboveStable <= aboveSync[2];
            end
            if (belowSync[1] == belowSync[2]) begin
                belowStable <= belowSync[2];
            end
        end
    end

    // Both comparators at once is treated as in range so 11 never appears
    always_comb begin
        candidate = SFFC_IN_RANGE; // RULE5
        if (ecMode && aboveStable && !belowStable) begin
            candidate = SFFC_ABOVE;
        end else if (ecMode && belowStable && !aboveStable) begin
            candidate = SFFC_BELOW;
        end
    end

    // A candidate must persist the full time before it is shown
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            last_reg <= SFFC_IN_RANGE;
            cnt_reg <= '0;
            shown_reg <= SFFC_IN_RANGE;
        end else if (clkEn) begin
            last_reg <= candidate;
            if (candidate != last_reg || candidate == shown_reg) begin
                cnt_reg <= '0;
            end else if (cnt_reg == CNT_MAX) begin
                shown_reg <= candidate; // RULE6 RULE7
                cnt_reg <= '0;
            end else begin
                cnt_reg <= cnt_reg + 1'b1;
            end
        end
    end

    // Unlatched: the shown state simply follows the filtered comparators
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ecAbove <= 1'b0;
            ecBelow <= 1'b0;
        end else if (clkEn) begin
            ecAbove <= (shown_reg == SFFC_ABOVE); // RULE5 RULE7
            ecBelow <= (shown_reg == SFFC_BELOW);
        end
    end
endmodule

// ==== core/sffc_top.sv ====
// Supply fault flags, mirror status reporting and diagnostic mask configuration register
module sffc_top
    import sffc_pkg::*;
#(
    parameter int NUM_OUT = 12,
    parameter int FILT_CYC = EC_FILT_CYC
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic clkEn,
    input wire logic [REG_ADDR_W-1:0] regAddr,
    input wire logic [REG_DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [REG_DATA_W-1:0] regRdata,
    input wire logic supplyFaultLatchCtl,
    input wire logic supplyLowIn,
    input wire logic supplyHighIn,
    input wire logic ecMode,
    input wire logic ecCmpAbove,
    input wire logic ecCmpBelow,
    input wire logic [NUM_OUT-1:0] underloadEvt,
    input wire logic thermalWarnIn,
    input wire logic otherErrIn,
    output logic outputsEnable,
    output logic supplyLowFlag,
    output logic supplyHighFlag,
    output logic ecAboveTarget,
    output logic ecBelowTarget,
    output logic globalUnderloadFlag,
    output logic thermalWarnFlag,
    output logic globalErrFlag,
    output logic mirrorPwmDischargeEn,
    output logic mirrorOcRecoveryEn
);
    logic [REG_DATA_W-1:0] config_reg;
    logic [SYNC_STAGES-1:0] uvSync;
    logic [SYNC_STAGES-1:0] ovSync;
    logic uvLevel;
    logic ovLevel;
    logic ecAbove;
    logic ecBelow;
    logic [NUM_OUT-1:0] uldMask;
    logic wrConfig;
    logic rdStatus;
    logic rdConfig;

    // Address compare shared by every strobe decode
    function automatic logic addrHit(input logic [REG_ADDR_W-1:0] addr, input logic [REG_ADDR_W-1:0] target);
        return addr == target;
    endfunction

    // Strobe decodes; a strobe at any other address does nothing
    assign wrConfig = regWr && addrHit(regAddr, CONFIG_ADDR);
    assign rdConfig = regRd && addrHit(regAddr, CONFIG_ADDR);
    assign rdStatus = regRd && addrHit(regAddr, STATUS2_ADDR);

    // Mirror comparators go through the filter
    sffc_ec_filter #(
        .FILT_CYC(FILT_CYC)
    ) u_ec_filter (
        .core_clk(core_clk),
        .nrst(nrst),
        .clkEn(clkEn),
        .ecMode(ecMode),
        .cmpAbove(ecCmpAbove),
        .cmpBelow(ecCmpBelow),
        .ecAbove(ecAbove),
        .ecBelow(ecBelow)
    );

    // Supply comparators come from the analog side, so three stages each
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            uvSync <= '0;
            ovSync <= '0;
        end else if (clkEn) begin
            uvSync <= {uvSync[SYNC_STAGES-2:0], supplyLowIn};
            ovSync <= {ovSync[SYNC_STAGES-2:0], supplyHighIn};
        end
    end

    // Level changes only when stages two and three agree
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            uvLevel <= 1'b0;
            ovLevel <= 1'b0;
        end else if (clkEn) begin
            if (uvSync[1] == uvSync[2]) begin
                uvLevel <= uvSync[2];
            end
            if (ovSync[1] == ovSync[2]) begin
                ovLevel <= ovSync[2];
            end
        end
    end

    // Configuration register: reserved bits never store anything
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            config_reg <= CONFIG_RESET; // RULE12
        end else if (clkEn && wrConfig) begin
            config_reg <= regWdata & CONFIG_WMASK; // RULE12 RULE15
        end
    end

    // Supply flags: a live fault sets the flag and wins over a clear in the same cycle
    // With latch control high, a status read is the only path that clears a flag
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            supplyLowFlag <= 1'b0;
            supplyHighFlag <= 1'b0;
        end else if (clkEn) begin
            if (uvLevel) begin
                supplyLowFlag <= 1'b1; // RULE1
            end else if (!supplyFaultLatchCtl) begin
                supplyLowFlag <= 1'b0; // RULE2
            end else if (rdStatus) begin
                supplyLowFlag <= 1'b0; // RULE2
            end
            if (ovLevel) begin
                supplyHighFlag <= 1'b1; // RULE3
            end else if (!supplyFaultLatchCtl) begin
                supplyHighFlag <= 1'b0; // RULE4
            end else if (rdStatus) begin
                supplyHighFlag <= 1'b0; // RULE4
            end
        end
    end

    // Outputs stop in the same edge the fault is seen, not a cycle after the flag
    // Limitation: the pin-to-enable delay includes the synchroniser, about five clocks
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            outputsEnable <= 1'b0;
        end else if (clkEn) begin
            outputsEnable <= !uvLevel && !ovLevel && // RULE1 RULE3
                             !(supplyFaultLatchCtl && (supplyLowFlag || supplyHighFlag)); // RULE2 RULE4
        end
    end

    // Per-output mask for the global underload summary
    always_comb begin
        uldMask = '0;
        uldMask[ULD_HS1] = config_reg[CFG_MASK_ULD_HIGH1]; // RULE9
        uldMask[ULD_LS1] = config_reg[CFG_MASK_ULD_LOW1]; // RULE9
        if (config_reg[CFG_MASK_ULD_ALL]) begin
            uldMask = '1; // RULE10
        end
    end

    // Global underload; a status read clears it, an event in the same cycle wins over the clear
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            globalUnderloadFlag <= 1'b0;
        end else if (clkEn) begin
            if (|(underloadEvt & ~uldMask)) begin
                globalUnderloadFlag <= 1'b1; // RULE14
            end else if (rdStatus) begin
                globalUnderloadFlag <= 1'b0;
            end
        end
    end

    // Global thermal warning, unlatched, one cycle behind the raw input
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            thermalWarnFlag <= 1'b0;
        end else if (clkEn) begin
            thermalWarnFlag <= thermalWarnIn && !config_reg[CFG_MASK_THERM]; // RULE11
        end
    end

    // Global error collects faults only; mirror status is deliberately left out
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            globalErrFlag <= 1'b0;
        end else if (clkEn) begin
            globalErrFlag <= supplyLowFlag || supplyHighFlag || globalUnderloadFlag || // RULE8
                             thermalWarnFlag || otherErrIn;
        end
    end

    // Mirror discharge control; recovery is forced off while discharge runs
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            mirrorPwmDischargeEn <= 1'b0;
            mirrorOcRecoveryEn <= 1'b1;
        end else if (clkEn) begin
            mirrorPwmDischargeEn <= config_reg[CFG_PWM_DIS]; // RULE13
            mirrorOcRecoveryEn <= !config_reg[CFG_PWM_DIS]; // RULE13
        end
    end

    // Mirror status registered once more so outputs stay flop-driven
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ecAboveTarget <= 1'b0;
            ecBelowTarget <= 1'b0;
        end else if (clkEn) begin
            ecAboveTarget <= ecAbove; // RULE5
            ecBelowTarget <= ecBelow; // RULE5
        end
    end

    // Read data, one cycle after the strobe; unmapped addresses read zero
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            regRdata <= '0;
        end else if (clkEn) begin
            regRdata <= '0;
            if (rdConfig) begin
                regRdata <= config_reg; // RULE15
            end else if (rdStatus) begin
                regRdata[ST_UV] <= supplyLowFlag;
                regRdata[ST_OV] <= supplyHighFlag;
                regRdata[ST_BELOW] <= ecBelowTarget;
                regRdata[ST_ABOVE] <= ecAboveTarget;
            end
        end
    end
endmodule

// ==== tb/sffc_top_monitor.sv ====
// Concurrent checks on supply fault, mirror status and mask outputs
module sffc_top_monitor
    import sffc_pkg::*;
#(
    parameter int NUM_OUT = 12,
    parameter int FILT_CYC = EC_FILT_CYC
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [NUM_OUT-1:0] underloadEvt,
    input wire logic thermalWarnIn,
    input wire logic otherErrIn,
    input wire logic outputsEnable,
    input wire logic supplyLowFlag,
    input wire logic supplyHighFlag,
    input wire logic ecAboveTarget,
    input wire logic ecBelowTarget,
    input wire logic globalUnderloadFlag,
    input wire logic thermalWarnFlag,
    input wire logic globalErrFlag,
    input wire logic mirrorPwmDischargeEn,
    input wire logic mirrorOcRecoveryEn
);
    timeunit 1ns;
    timeprecision 100ps;
    int ecGap;
    logic [1:0] ecPrev;
    wire logic errSrc = supplyLowFlag | supplyHighFlag | otherErrIn | globalUnderloadFlag | (|underloadEvt)
        | thermalWarnFlag | thermalWarnIn;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // Cycles since the status pair last moved; saturates so it never wraps
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ecGap <= 0;
            ecPrev <= 2'h0;
        end else begin
            ecPrev <= {ecAboveTarget, ecBelowTarget};
            if (ecPrev != {ecAboveTarget, ecBelowTarget}) begin
                ecGap <= 1;
            end else if (ecGap < FILT_CYC) begin
                ecGap <= ecGap + 1;
            end
        end
    end
    a_uv_stops_out: assert property (supplyLowFlag |-> !outputsEnable)
        else $error("outputs on while supply low");
    a_ov_stops_out: assert property (supplyHighFlag |-> !outputsEnable)
        else $error("outputs on while supply high");
    a_ec_pair_legal: assert property (!(ecAboveTarget && ecBelowTarget))
        else $error("mirror pair shows both bits");
    a_ec_change_gap: assert property ((ecPrev != {ecAboveTarget, ecBelowTarget}) |-> ecGap >= FILT_CYC)
        else $error("mirror pair changed too soon");
    a_pwm_no_recov: assert property (mirrorPwmDischargeEn != mirrorOcRecoveryEn)
        else $error("recovery not opposite to discharge");
    a_uld_global_cause: assert property ($rose(globalUnderloadFlag) |-> $past(|underloadEvt))
        else $error("global underload without event");
    a_tw_flag_cause: assert property (thermalWarnFlag |-> $past(thermalWarnIn))
        else $error("thermal flag without warning");
    a_err_no_mirror: assert property ($rose(globalErrFlag) |-> $past(errSrc) || $past(errSrc, 2))
        else $error("global error without a fault source");
endmodule

bind sffc_top sffc_top_monitor #(.NUM_OUT(NUM_OUT), .FILT_CYC(FILT_CYC)) i_mon (.core_clk(core_clk), .nrst(nrst),
    .underloadEvt(underloadEvt), .thermalWarnIn(thermalWarnIn), .otherErrIn(otherErrIn),
    .outputsEnable(outputsEnable), .supplyLowFlag(supplyLowFlag), .supplyHighFlag(supplyHighFlag),
    .ecAboveTarget(ecAboveTarget), .ecBelowTarget(ecBelowTarget), .globalUnderloadFlag(globalUnderloadFlag),
    .thermalWarnFlag(thermalWarnFlag), .globalErrFlag(globalErrFlag),
    .mirrorPwmDischargeEn(mirrorPwmDischargeEn), .mirrorOcRecoveryEn(mirrorOcRecoveryEn));

// ==== tb/sffc_host.sv ====
// Host controller model driving the register port
module sffc_host
    import sffc_pkg::*;
(
    input wire logic core_clk,
    input wire logic [REG_DATA_W-1:0] regRdata,
    output logic [REG_ADDR_W-1:0] regAddr,
    output logic [REG_DATA_W-1:0] regWdata,
    output logic regWr,
    output logic regRd
);
    timeunit 1ns;
    timeprecision 100ps;
    // Idle bus at time zero
    initial begin
        regAddr = 6'h00;
        regWdata = 16'h0000;
        regWr = 1'b0;
        regRd = 1'b0;
    end
    // Data goes to its inverse once released so a stale value cannot pass
    task automatic wr(input logic [REG_ADDR_W-1:0] a, input logic [REG_DATA_W-1:0] d);
        @(negedge core_clk);
        regAddr = a;
        regWdata = d;
        regWr = 1'b1;
        @(negedge core_clk);
        regWr = 1'b0;
        regWdata = ~d;
    endtask
    // Read data is registered, so it is taken one edge after the strobe
    task automatic rd(input logic [REG_ADDR_W-1:0] a, output logic [REG_DATA_W-1:0] d);
        @(negedge core_clk);
        regAddr = a;
        regRd = 1'b1;
        @(negedge core_clk);
        regRd = 1'b0;
        d = regRdata;
    endtask
endmodule

// ==== tb/sffc_top_tb.sv ====
// Self-checking bench for the supply fault, mirror status and mask block
module sffc_top_tb
    import sffc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int FILT = 16;
    logic core_clk, nrst, latchCtl, lowIn, highIn, ecMode, cmpAbove, cmpBelow, thermIn;
    logic [11:0] uldEvt;
    logic [5:0] addr;
    logic [15:0] wdata, rdata, d;
    logic wr, rd, oe, lowF, highF, above, below, gUld, thermF, gErr, pwmEn, ocRec;
    int fail_count = 0;
    int total_checks = 0;
    logic [15:0] cfgTab [7] = '{16'h0000, 16'h0020, 16'h0020, 16'h0010, 16'h0010, 16'h0002, 16'h0000};
    int bitTab [7] = '{0, 0, 1, 1, 0, 5, 5};
    logic expTab [7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    sffc_host i_host (.core_clk(core_clk), .regRdata(rdata), .regAddr(addr), .regWdata(wdata), .regWr(wr),
        .regRd(rd));
    sffc_top #(.FILT_CYC(FILT)) i_dut (.core_clk(core_clk), .nrst(nrst), .clkEn(1'b1), .regAddr(addr),
        .regWdata(wdata), .regWr(wr), .regRd(rd), .regRdata(rdata), .supplyFaultLatchCtl(latchCtl),
        .supplyLowIn(lowIn), .supplyHighIn(highIn), .ecMode(ecMode), .ecCmpAbove(cmpAbove), .ecCmpBelow(cmpBelow),
        .underloadEvt(uldEvt), .thermalWarnIn(thermIn), .otherErrIn(1'b0), .outputsEnable(oe),
        .supplyLowFlag(lowF), .supplyHighFlag(highF), .ecAboveTarget(above), .ecBelowTarget(below),
        .globalUnderloadFlag(gUld), .thermalWarnFlag(thermF), .globalErrFlag(gErr),
        .mirrorPwmDischargeEn(pwmEn), .mirrorOcRecoveryEn(ocRec));
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic print_verdict;
        if (fail_count == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Waits cover the three-flop synchroniser plus the flag and enable flops
    task automatic supply(input logic hi, input logic latch);
        latchCtl = latch;
        {highIn, lowIn} = hi ? 2'b10 : 2'b01;
        repeat (8) @(negedge core_clk);
        chk("fault flag", hi ? highF : lowF, 16'h0001);
        chk("outputs off", oe, 16'h0000);
        chk("global error", gErr, 16'h0001);
        i_host.rd(STATUS2_ADDR, d);
        chk("status fault", d, hi ? 16'h0004 : 16'h0008);
        {highIn, lowIn} = 2'b00;
        repeat (8) @(negedge core_clk);
        chk("outputs resume", oe, latch ? 16'h0000 : 16'h0001);
        i_host.rd(STATUS2_ADDR, d);
        repeat (3) @(negedge core_clk);
        chk("outputs after clear", oe, 16'h0001);
    endtask
    // Pair must still show the old value a full filter span in, then the new one once sync delay is also past
    task automatic ecStep(input logic a, input logic b, input logic [15:0] prev, input logic [15:0] exp);
        cmpAbove = a;
        cmpBelow = b;
        repeat (FILT) @(negedge core_clk);
        chk("mirror hold", {above, below}, prev);
        repeat (FILT / 2 + 8) @(negedge core_clk);
        chk("mirror pair", {above, below}, exp);
    endtask
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    // Hang guard, far above the few hundred cycles the sequence needs
    initial begin
        repeat (4000) @(posedge core_clk);
        fail_count++;
        print_verdict();
    end
    initial begin
        {nrst, latchCtl, lowIn, highIn, ecMode, cmpAbove, cmpBelow, thermIn} = 8'h00;
        uldEvt = 12'h000;
        repeat (12) @(negedge core_clk);
        nrst = 1'b1;
        i_host.rd(CONFIG_ADDR, d);
        chk("config reset", d, 16'h0000);
        chk("recovery reset", {pwmEn, ocRec}, 16'h0001);
        i_host.wr(CONFIG_ADDR, 16'hFFFF);
        i_host.wr(STATUS2_ADDR, 16'h0000);
        i_host.rd(CONFIG_ADDR, d);
        chk("config bits", d, 16'h00BA);
        chk("discharge on", {pwmEn, ocRec}, 16'h0002);
        i_host.rd(6'h05, d);
        chk("unmapped read", d, 16'h0000);
        for (int i = 0; i < 7; i++) begin
            i_host.wr(CONFIG_ADDR, cfgTab[i]);
            i_host.rd(STATUS2_ADDR, d);
            @(negedge core_clk) uldEvt = 12'h001 << bitTab[i];
            @(negedge core_clk) uldEvt = 12'h000;
            chk("global underload", gUld, {15'h0000, expTab[i]});
        end
        for (int m = 0; m < 2; m++) begin
            i_host.wr(CONFIG_ADDR, m ? 16'h0008 : 16'h0000);
            thermIn = 1'b1;
            repeat (2) @(negedge core_clk);
            chk("thermal warn", thermF, m ? 16'h0000 : 16'h0001);
            thermIn = 1'b0;
        end
        for (int k = 0; k < 4; k++) begin
            supply(k[0], k[1]);
        end
        i_host.rd(STATUS2_ADDR, d);
        ecMode = 1'b1;
        ecStep(1'b1, 1'b0, 16'h0000, 16'h0002);
        chk("no mirror error", gErr, 16'h0000);
        i_host.rd(STATUS2_ADDR, d);
        chk("status above", d, 16'h0001);
        ecStep(1'b1, 1'b1, 16'h0002, 16'h0000);
        ecStep(1'b0, 1'b1, 16'h0000, 16'h0001);
        ecMode = 1'b0;
        repeat (FILT + 8) @(negedge core_clk);
        chk("mirror mode off", {above, below}, 16'h0000);
        // Mid-run reset must bring a written configuration back to zero
        i_host.wr(CONFIG_ADDR, 16'h00BA);
        nrst = 1'b0;
        repeat (2) @(negedge core_clk);
        nrst = 1'b1;
        i_host.rd(CONFIG_ADDR, d);
        chk("config after reset", d, 16'h0000);
        chk("recovery after reset", {pwmEn, ocRec}, 16'h0001);
        print_verdict();
    end
endmodule
